// [logic/fca_array.sv]
// Purpose: eight-cell systolic fir multiply-accumulate array with output stage
// Assumes: all pins except rst_b synchronous to ref_clk; far side sequences samples and controls
// Notes: result_bus enables are active low; the fifo captures each newly selected result unless full
// Operation
// - four pipeline stages: input register, two multiplier registers, result holding.
// - first sum appears filter length plus three clocks after first input.
// - after fill, one new output per clock, cells in turn.
// - last output exactly four clocks after last input sample.
// - eight-tap output is sum of coefficient times delayed sample.
// - during trailing zeros results are read and accumulators cleared.
// - decimation by two or three supported.
// - each cell delays coefficients by one, two or three clocks.
// - hold register loads every clock except the one after cell selection.
// - clear without reset clears only the addressed cell accumulator.
// - output mux picks cell when shift-add low now and before.
// - sample register loads one clock after enable low; zeros while high.
`timescale 1ns/1ps
`default_nettype none
module fca_array #(
    parameter int CELLS = fca_pkg::NUM_CELLS,
    parameter int DEPTH = fca_pkg::FIFO_DEPTH
) (
    input wire logic ref_clk, // sample clock
    input wire logic rst_b, // async reset, active low
    input wire logic reset_n, // synchronous register clear pin
    input wire logic erase_n, // accumulator clear pin
    input wire logic [fca_pkg::SAMPLE_W-1:0] sample_in, // sample bus
    input wire logic sample_load_en_n, // sample enable, active low
    input wire logic [fca_pkg::SAMPLE_W-1:0] coeff_in, // coefficient bus
    input wire logic [1:0] decim_sel, // coefficient delay select
    input wire logic [fca_pkg::SEL_W-1:0] cell_sel, // cell address
    input wire logic shift_add_sel, // shift-and-add control
    input wire logic result_low_oe_n, // low result lane enable
    input wire logic result_high_oe_n, // high result lane enable
    output logic [fca_pkg::SAMPLE_W-1:0] coeff_out, // coefficient cascade output
    output logic [fca_pkg::ACC_W-1:0] result_bus, // result bus value
    output logic [fca_pkg::ACC_W-1:0] result_oe, // per-bit drive enable
    output logic [fca_pkg::ACC_W-1:0] fifo_data, // buffered result
    output logic fifo_valid, // buffered result valid
    input wire logic fifo_ready, // buffered result accept
    output logic fifo_full // result fifo full
);
    localparam int SW = fca_pkg::SAMPLE_W;
    localparam int AW = fca_pkg::ACC_W;
    initial begin
        if (CELLS != (1 << fca_pkg::SEL_W)) begin
            $error("fca_array: cell count must match address width");
        end
    end

    logic [1:0] rst_sync_q;
    logic rst_n;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // control pins latched one clock
    logic reset_q;
    logic erase_q;
    logic sen_q;
    logic shift_add_sel_q;
    logic shift_add_sel_prev_q;
    logic [fca_pkg::SEL_W-1:0] sel_q;
    logic [fca_pkg::SEL_W-1:0] sel_prev_q;
    logic [1:0] decim_q;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reset_q <= 1'b0;
            erase_q <= 1'b0;
            sen_q <= 1'b0;
            shift_add_sel_q <= 1'b0;
            shift_add_sel_prev_q <= 1'b0;
            sel_q <= '0;
            sel_prev_q <= '0;
            decim_q <= fca_pkg::DECIM_RST;
        end else begin
            reset_q <= !reset_n;
            erase_q <= !erase_n;
            sen_q <= !sample_load_en_n;
            shift_add_sel_q <= shift_add_sel;
            shift_add_sel_prev_q <= shift_add_sel_q;
            sel_q <= cell_sel;
            sel_prev_q <= sel_q;
            decim_q <= decim_sel;
        end
    end
    logic clr_all;
    logic clr_acc_all;
    assign clr_all = reset_q;
    assign clr_acc_all = reset_q && erase_q;

    // broadcast sample register; coefficient chain through cells
    logic signed [SW-1:0] x_q;
    logic signed [SW-1:0] c_in_q;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            x_q <= '0;
            c_in_q <= '0;
        end else if (clr_all) begin
            x_q <= '0;
            c_in_q <= '0;
        end else begin
            x_q <= sen_q ? sample_in : '0;
            c_in_q <= coeff_in;
        end
    end

    logic signed [SW-1:0] chain [CELLS+1];
    logic signed [AW-1:0] acc_q [CELLS];
    logic signed [AW-1:0] hold_q [CELLS];
    assign chain[0] = c_in_q;

    genvar g;
    generate
        for (g = 0; g < CELLS; g++) begin : gen_cell
            logic signed [SW-1:0] d_q [fca_pkg::MAX_DECIM-1];
            logic signed [fca_pkg::PROD_W-1:0] ma_q;
            logic signed [fca_pkg::PROD_W-1:0] mb_q;
            logic signed [AW-1:0] sum;
            logic hit;
            assign hit = sel_q == fca_pkg::SEL_W'(g);
            // coefficient delay: one, two or three registers
            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    d_q[0] <= '0;
                    d_q[1] <= '0;
                    d_q[2] <= '0;
                end else if (clr_all) begin
                    d_q[0] <= '0;
                    d_q[1] <= '0;
                    d_q[2] <= '0;
                end else begin
                    d_q[0] <= chain[g];
                    d_q[1] <= d_q[0];
                    d_q[2] <= d_q[1];
                end
            end
            always_comb begin
                unique case (fca_pkg::fca_decim_t'(decim_q))
                    fca_pkg::FCA_DLY2: chain[g+1] = d_q[1];
                    fca_pkg::FCA_DLY3: chain[g+1] = d_q[2];
                    default: chain[g+1] = d_q[0];
                endcase
            end
            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    ma_q <= '0;
                    mb_q <= '0;
                end else if (clr_all) begin
                    ma_q <= '0;
                    mb_q <= '0;
                end else begin
                    ma_q <= chain[g] * x_q;
                    mb_q <= ma_q;
                end
            end
            // a fresh sum starts once the cell has been selected
            assign sum = (hit ? AW'(0) : acc_q[g]) + AW'(mb_q);
            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    acc_q[g] <= '0;
                    hold_q[g] <= '0;
                end else begin
                    if (clr_acc_all || (erase_q && !reset_q && hit)) begin
                        acc_q[g] <= '0;
                    end else begin
                        acc_q[g] <= sum;
                    end
                    if (clr_all) begin
                        hold_q[g] <= '0;
                    end else if (!hit) begin
                        hold_q[g] <= sum;
                    end
                end
            end
        end
    endgenerate
    assign coeff_out = chain[CELLS];

    // output stage: shift-and-add buffer and output mux
    logic signed [AW-1:0] cell_val;
    logic signed [AW-1:0] buf_q;
    logic signed [AW-1:0] mux_val;
    logic new_sel;
    assign cell_val = hold_q[sel_q];
    assign new_sel = sel_q != sel_prev_q;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            buf_q <= '0;
        end else if (clr_all) begin
            buf_q <= '0;
        end else begin
            buf_q <= cell_val + (shift_add_sel_q ? (buf_q >>> fca_pkg::SHIFT_BITS) : AW'(0));
        end
    end
    assign mux_val = (!shift_add_sel_q && !shift_add_sel_prev_q) ? cell_val : buf_q;

    // result register freezes while the address stands and shift-add is low now and before
    logic [AW-1:0] res_q;
    logic [AW-1:0] oe_q;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            res_q <= '0;
            oe_q <= '0;
        end else begin
            if (new_sel || shift_add_sel_q || shift_add_sel_prev_q) begin
                res_q <= mux_val;
            end
            oe_q <= {{(AW-fca_pkg::LOW_W){!result_high_oe_n}}, {fca_pkg::LOW_W{!result_low_oe_n}}};
        end
    end
    assign result_bus = res_q;
    assign result_oe = oe_q;

    logic in_ready;
    logic [AW-1:0] f_data;
    logic f_valid;
    logic full_q;
    logic fv_q;
    logic [AW-1:0] fd_q;
    fca_fifo #(.WIDTH(AW), .DEPTH(DEPTH)) u_fifo (
        .clk(ref_clk),
        .rst_n(rst_n),
        .in_data(mux_val),
        .in_valid(new_sel),
        .in_ready(in_ready),
        .out_data(f_data),
        .out_valid(f_valid),
        .out_ready(fifo_ready && fv_q)
    );
    // registered view of fifo head; pop only after it has been shown
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            full_q <= 1'b0;
            fv_q <= 1'b0;
            fd_q <= '0;
        end else begin
            // a pop this clock frees a slot, so full never outlives the valid view
            full_q <= !in_ready && !(fifo_ready && fv_q);
            fv_q <= f_valid && !(fifo_ready && fv_q);
            fd_q <= f_data;
        end
    end
    assign fifo_full = full_q;
    assign fifo_valid = fv_q;
    assign fifo_data = fd_q;
endmodule
`default_nettype wire

// [logic/fca_pkg.sv]
// Purpose: shared constants and types for the eight-cell fir array
// Assumes: one sample clock, synchronous control pins
// Notes: none
`default_nettype none
package fca_pkg;
    localparam int NUM_CELLS = 8;
    localparam int SAMPLE_W = 9;
    localparam int PROD_W = 18;
    localparam int ACC_W = 26;
    localparam int SEL_W = 3;
    localparam int PIPE_STAGES = 4;
    localparam int MAX_DECIM = 4;
    localparam int LOW_W = 16;
    localparam int SHIFT_BITS = 8;
    localparam int FIFO_DEPTH = 16;
    localparam logic [1:0] DECIM_RST = 2'h0;

    typedef struct packed {
        logic [ACC_W-1:0] sum;
    } fca_result_t;

    typedef enum logic [1:0] {
        FCA_DLY1,
        FCA_DLY2,
        FCA_DLY3,
        FCA_DLY_RSVD
    } fca_decim_t;
endpackage
`default_nettype wire

// [logic/fca_fifo.sv]
// Purpose: result fifo with valid/ready on both sides
// Assumes: depth is a power of two
// Notes: flip-flop storage addressed by index
`timescale 1ns/1ps
`default_nettype none
module fca_fifo #(
    parameter int WIDTH = 26,
    parameter int DEPTH = 16
) (
    input wire logic clk, // clock
    input wire logic rst_n, // synchronous-released reset
    input wire logic [WIDTH-1:0] in_data, // write data
    input wire logic in_valid, // write request
    output logic in_ready, // not full
    output logic [WIDTH-1:0] out_data, // head data
    output logic out_valid, // not empty
    input wire logic out_ready // read accept
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
            $error("fca_fifo: depth must be a power of two >= 2");
        end
    end
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    logic push;
    logic pop;
    assign in_ready = (wr_q - rd_q) != (AW+1)'(DEPTH);
    assign out_valid = wr_q != rd_q;
    assign out_data = mem_q[rd_q[AW-1:0]];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q[AW-1:0]] <= in_data;
        end
    end
endmodule
`default_nettype wire

// [testbench/fca_array_assertions.sv]
// Purpose: port-level checks for the fir array
// Assumes: one clock, rst_b async active low
// Notes: bound into fca_array
`timescale 1ns/1ps
`default_nettype none
module fca_array_assertions (
    input wire logic ref_clk, // clock
    input wire logic rst_b, // async reset
    input wire logic reset_n, // register clear
    input wire logic sample_load_en_n, // sample enable
    input wire logic [8:0] coeff_in, // coefficient in
    input wire logic [2:0] cell_sel, // cell address
    input wire logic shift_add_sel, // shift-add
    input wire logic result_low_oe_n, // low lane enable
    input wire logic result_high_oe_n, // high lane enable
    input wire logic [8:0] coeff_out, // coefficient out
    input wire logic [25:0] result_bus, // result
    input wire logic [25:0] result_oe, // drive enables
    input wire logic [25:0] fifo_data, // fifo head
    input wire logic fifo_valid, // fifo valid
    input wire logic fifo_ready, // fifo accept
    input wire logic fifo_full // fifo full
);
    logic [2:0] live_q;
    logic [5:0] zx_q;
    logic [5:0] zc_q;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // cycles since both resets went away, and length of zero input runs
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) live_q <= 3'h0;
        else if (!reset_n) live_q <= 3'h0;
        else if (live_q != 3'h4) live_q <= live_q + 3'h1;
    end
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) zx_q <= 6'h00;
        else if (!sample_load_en_n) zx_q <= 6'h00;
        else if (zx_q != 6'h3F) zx_q <= zx_q + 6'h01;
    end
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) zc_q <= 6'h00;
        else if (coeff_in != 9'h000) zc_q <= 6'h00;
        else if (zc_q != 6'h3F) zc_q <= zc_q + 6'h01;
    end
    property p_oe_low;
        live_q == 3'h4 |-> result_oe[15:0] == {16{!$past(result_low_oe_n)}};
    endproperty
    a_oe_low: assert property (p_oe_low) else $error("low lane enable wrong");
    property p_oe_high;
        live_q == 3'h4 |-> result_oe[25:16] == {10{!$past(result_high_oe_n)}};
    endproperty
    a_oe_high: assert property (p_oe_high) else $error("high lane enable wrong");
    property p_hold;
        (live_q == 3'h4 && !shift_add_sel && $stable(cell_sel))[*4] |-> $stable(result_bus);
    endproperty
    a_hold: assert property (p_hold) else $error("result moved on held address");
    property p_zero_load;
        zx_q >= 6'h28 && !shift_add_sel && cell_sel != $past(cell_sel) |-> ##2 result_bus == 26'h0;
    endproperty
    a_zero_load: assert property (p_zero_load) else $error("nonzero sum with enable high");
    property p_rst_out;
        $rose(rst_b) |-> result_bus == 26'h0 && result_oe == 26'h0 && !fifo_valid;
    endproperty
    a_rst_out: assert property (p_rst_out) else $error("outputs not cleared by reset");
    property p_coeff_idle;
        zc_q >= 6'h20 |-> coeff_out == 9'h000;
    endproperty
    a_coeff_idle: assert property (p_coeff_idle) else $error("stale coefficient out");
    property p_fifo_hold;
        live_q == 3'h4 && fifo_valid && !fifo_ready |=> fifo_valid && $stable(fifo_data);
    endproperty
    a_fifo_hold: assert property (p_fifo_hold) else $error("fifo head changed unread");
    property p_full_valid;
        fifo_full |-> fifo_valid;
    endproperty
    a_full_valid: assert property (p_full_valid) else $error("full fifo shows empty");
endmodule
bind fca_array fca_array_assertions fca_array_assertions_i (.ref_clk, .rst_b, .reset_n,
    .sample_load_en_n, .coeff_in, .cell_sel, .shift_add_sel, .result_low_oe_n,
    .result_high_oe_n, .coeff_out, .result_bus, .result_oe, .fifo_data, .fifo_valid,
    .fifo_ready, .fifo_full);
`default_nettype wire

// [testbench/fca_seq_model.sv]
// Purpose: sequencing logic with a constant sample and a cyclic coefficient set
// Assumes: highest tap enters first, taps c0 + k*step
// Notes: pulse injects one marker coefficient
`timescale 1ns/1ps
`default_nettype none
module fca_seq_model (
    input wire logic clk, // sample clock
    input wire logic [8:0] x, // sample to repeat
    input wire logic [8:0] c0, // tap 0 coefficient
    input wire logic [8:0] step, // step between taps
    input wire logic pulse, // marker request
    input wire logic hold, // freeze the address
    output logic [8:0] sample_in = 9'h000, // sample bus
    output logic [8:0] coeff_in = 9'h000, // coefficient bus
    output logic [2:0] cell_sel = 3'h0 // cell address
);
    logic [2:0] k_q = 3'h0;
    always @(posedge clk) begin
        k_q <= k_q + 3'h1;
        sample_in <= x;
        coeff_in <= pulse ? 9'h0AA : c0 + 9'(3'h7 - k_q) * step;
        if (!hold) cell_sel <= k_q;
    end
endmodule
`default_nettype wire

// [testbench/tb_fca_array.sv]
// Purpose: self-checking bench for the fir array
// Assumes: constant samples, so every full sum is x times the tap sum
// Notes: rows hold sample, taps, lane enables and expected outputs
`timescale 1ns/1ps
`default_nettype none
module tb_fca_array;
    typedef struct packed {
        logic [8:0] x;
        logic [8:0] c0;
        logic [8:0] step;
        logic [1:0] oe_n;
        logic [25:0] y;
        logic [25:0] oe;
    } fca_row_t;
    fca_row_t rows [3] = '{
        '{9'h003, 9'h001, 9'h001, 2'h2, 26'h000006C, 26'h000FFFF},
        '{9'h1FE, 9'h005, 9'h1FF, 2'h1, 26'h3FFFFE8, 26'h3FF0000},
        '{9'h0FF, 9'h100, 9'h000, 2'h0, 26'h3F80800, 26'h3FFFFFF}};
    logic ref_clk = 1'b0, rst_b = 1'b0, reset_n = 1'b0, erase_n = 1'b0;
    logic sample_load_en_n = 1'b0, shift_add_sel = 1'b0, fifo_ready = 1'b1;
    logic result_low_oe_n = 1'b1, result_high_oe_n = 1'b1, pulse = 1'b0, hold = 1'b0;
    logic [1:0] decim_sel = 2'h0;
    logic [8:0] x = 9'h000, c0 = 9'h000, step = 9'h000;
    logic [8:0] sample_in, coeff_in, coeff_out;
    logic [2:0] cell_sel;
    logic [25:0] result_bus, result_oe, fifo_data;
    logic fifo_valid, fifo_full;
    int num_errors = 0, num_checks = 0, cyc = 0;
    int lat [4];
    fca_array #(.DEPTH(16)) fca_array_i (.ref_clk, .rst_b, .reset_n, .erase_n, .sample_in,
        .sample_load_en_n, .coeff_in, .decim_sel, .cell_sel, .shift_add_sel,
        .result_low_oe_n, .result_high_oe_n, .coeff_out, .result_bus, .result_oe,
        .fifo_data, .fifo_valid, .fifo_ready, .fifo_full);
    fca_seq_model fca_seq_model_i (.clk(ref_clk), .x, .c0, .step, .pulse, .hold,
        .sample_in, .coeff_in, .cell_sel);
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end
    task automatic stop_test;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 2000) begin
            num_errors++;
            stop_test();
        end
    end
    task automatic check(input logic [25:0] got, input logic [25:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // outputs are read at the falling edge, where they have settled
    task automatic run_chk(input logic [25:0] exp);
        tick(40);
        repeat (8) begin
            @(negedge ref_clk);
            check(result_bus, exp);
        end
        tick(1);
    endtask
    initial begin
        tick(16);
        rst_b <= 1'b1;
        reset_n <= 1'b1;
        erase_n <= 1'b1;
        tick(1);
        check(result_bus | result_oe | 26'(fifo_valid), 26'h0);
        foreach (rows[i]) begin
            x <= rows[i].x;
            c0 <= rows[i].c0;
            step <= rows[i].step;
            {result_high_oe_n, result_low_oe_n} <= rows[i].oe_n;
            run_chk(rows[i].y);
            check(result_oe, rows[i].oe);
            $display("row %0d done", i);
        end
        // steady buffer: y + (buffer >>> 8) settles at -524288 for the last row
        shift_add_sel <= 1'b1;
        tick(6);
        @(negedge ref_clk);
        check(result_bus, 26'h3F80000);
        tick(1);
        shift_add_sel <= 1'b0;
        tick(2);
        @(negedge ref_clk);
        check(result_bus, 26'h3F80000);
        @(negedge ref_clk);
        check(result_bus, rows[2].y);
        tick(1);
        $display("shift-add test done");
        // addressed clear drops one of eight equal products: 7 x 255 x -256
        erase_n <= 1'b0;
        run_chk(26'h3F90700);
        erase_n <= 1'b1;
        run_chk(rows[2].y);
        $display("erase test done");
        hold <= 1'b1;
        tick(6);
        hold <= 1'b0;
        check(result_bus, rows[2].y);
        fifo_ready <= 1'b0;
        for (int n = 0; n < 60 && fifo_full !== 1'b1; n++) tick(1);
        check(26'(fifo_full), 26'h1);
        fifo_ready <= 1'b1;
        repeat (16) begin
            tick(1);
            if (fifo_valid === 1'b1) check(fifo_data, rows[2].y);
        end
        $display("fifo test done");
        sample_load_en_n <= 1'b1;
        run_chk(26'h0);
        sample_load_en_n <= 1'b0;
        $display("sample enable test done");
        rst_b <= 1'b0;
        tick(2);
        rst_b <= 1'b1;
        tick(1);
        check(result_bus | result_oe | 26'(fifo_valid), 26'h0);
        $display("reset test done");
        x <= 9'h000;
        c0 <= 9'h000;
        step <= 9'h000;
        for (int d = 0; d < 4; d++) begin
            decim_sel <= 2'(d);
            tick(40);
            pulse <= 1'b1;
            tick(1);
            pulse <= 1'b0;
            lat[d] = 0;
            @(negedge ref_clk);
            while (coeff_out !== 9'h0AA && lat[d] < 80) begin
                @(negedge ref_clk);
                lat[d]++;
            end
            tick(1);
        end
        check(26'(lat[1] - lat[0]), 26'h8);
        check(26'(lat[2] - lat[0]), 26'h10);
        check(26'(lat[3] - lat[0]), 26'h0);
        $display("decimation test done");
        stop_test();
    end
endmodule
`default_nettype wire
